/* File: src/spp_nv_cell.sv */
// one nonvolatile parameter cell: holds a stored copy until a store strobe
`timescale 1ns/1ps
`default_nettype none
module spp_nv_cell #(
    parameter int              W   = 16,
    parameter logic [W-1:0]    RST = '0
) (
    input  wire logic          clk_i,     // system clock
    input  wire logic          reset_n_i, // async reset, active low
    input  wire logic          store_i,   // write strobe
    input  wire logic [W-1:0]  data_i,    // value to keep
    output logic      [W-1:0]  data_o     // kept value
);
    // reset stands in for the factory-programmed content of the memory
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            data_o <= RST;
        else if (store_i)
            data_o <= data_i;
    end
endmodule
`default_nettype wire

/* File: src/spp_pkg.sv */
// servo position parameter block: register map, reset values, limits
package spp_pkg;
    // register byte offsets (one aligned word each)
    localparam logic [7:0]  SPP_ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  SPP_ADDR_STATUS   = 8'h04;
    localparam logic [7:0]  SPP_ADDR_PGAIN    = 8'h08;
    localparam logic [7:0]  SPP_ADDR_IGAIN    = 8'h0C;
    localparam logic [7:0]  SPP_ADDR_DGAIN    = 8'h10;
    localparam logic [7:0]  SPP_ADDR_STEPMUL  = 8'h14;
    localparam logic [7:0]  SPP_ADDR_ENCMUL   = 8'h18;
    localparam logic [7:0]  SPP_ADDR_BAUD     = 8'h1C;
    localparam logic [7:0]  SPP_ADDR_POS      = 8'h20;
    localparam logic [7:0]  SPP_ADDR_VERSION  = 8'h24;
    localparam logic [7:0]  SPP_ADDR_NV_PGAIN = 8'h28;
    localparam logic [7:0]  SPP_ADDR_NV_IGAIN = 8'h2C;
    localparam logic [7:0]  SPP_ADDR_NV_DGAIN = 8'h30;
    localparam logic [7:0]  SPP_ADDR_NV_STEP  = 8'h34;
    localparam logic [7:0]  SPP_ADDR_NV_BAUD  = 8'h38;
    // control register command bits (write-one pulses)
    localparam int          SPP_CTRL_STORE_GAIN = 0;
    localparam int          SPP_CTRL_STORE_STEP = 1;
    localparam int          SPP_CTRL_STORE_BAUD = 2;
    localparam int          SPP_CTRL_LOAD_GAIN  = 3;
    localparam int          SPP_CTRL_CLR_POS    = 4;
    // widths and limits
    localparam int          SPP_GAIN_W   = 16;
    localparam logic [15:0] SPP_GAIN_MAX = 16'h8000;
    localparam logic [5:0]  SPP_STEP_MIN = 6'h01;
    localparam logic [5:0]  SPP_STEP_MAX = 6'h32;
    // reset values and encoder mode codes
    localparam logic [15:0] SPP_PGAIN_RST = 16'h0032;
    localparam logic [15:0] SPP_IGAIN_RST = 16'h0000;
    localparam logic [15:0] SPP_DGAIN_RST = 16'h0000;
    localparam logic [5:0]  SPP_STEP_RST  = 6'h01;
    localparam logic [1:0]  SPP_ENC_X1    = 2'h0;
    localparam logic [1:0]  SPP_ENC_X2    = 2'h1;
    localparam logic [1:0]  SPP_ENC_X4    = 2'h2;
    localparam logic [2:0]  SPP_BAUD_RST  = 3'h0;
    // arbitrary value, names no product
    localparam logic [15:0] SPP_FW_VERSION = 16'h0100;
    // bus responses
    localparam logic [1:0]  SPP_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  SPP_RESP_SLVERR = 2'h2;
endpackage

/* File: src/spp_top.sv */
// servo position parameters: step scaling, encoder decode, gain storage
//
// Behaviour
// RULE_01 each step pulse adds multiplier; range 1..50
// RULE_02 encoder counts one, two or four per cycle
// RULE_03 host can read stored gains back
// RULE_04 store command writes gains to storage
// RULE_05 store request writes step multiplier
// RULE_06 baud save writes rate to storage
// RULE_07 firmware version and all parameters readable
// RULE_08 gains unsigned 0..32768; defaults 50,0,0
`timescale 1ns/1ps
`default_nettype none
module spp_top
    import spp_pkg::*;
(
    input  wire logic        clk_i,          // 100 MHz clock
    input  wire logic        reset_n_i,      // async reset, active low
    input  wire logic        step_i,         // step command line
    input  wire logic        dir_i,          // direction, high = forward
    input  wire logic        enc_a_i,        // encoder channel a
    input  wire logic        enc_b_i,        // encoder channel b
    output logic [31:0]      cmd_pos_o,      // commanded position
    output logic [31:0]      fb_pos_o,       // feedback position
    output logic [15:0]      proportional_gain_o, // active gain
    output logic [15:0]      integral_gain_o,     // active gain
    output logic [15:0]      derivative_gain_o,   // active gain
    output logic [2:0]       baud_sel_o,     // stored baud selection
    input  wire logic [7:0]  s_axi_awaddr,   // write address
    input  wire logic        s_axi_awvalid,  // write address valid
    output logic             s_axi_awready,  // write address ready
    input  wire logic [31:0] s_axi_wdata,    // write data
    input  wire logic [3:0]  s_axi_wstrb,    // byte enables
    input  wire logic        s_axi_wvalid,   // write data valid
    output logic             s_axi_wready,   // write data ready
    output logic [1:0]       s_axi_bresp,    // write response
    output logic             s_axi_bvalid,   // write response valid
    input  wire logic        s_axi_bready,   // write response ready
    input  wire logic [7:0]  s_axi_araddr,   // read address
    input  wire logic        s_axi_arvalid,  // read address valid
    output logic             s_axi_arready,  // read address ready
    output logic [31:0]      s_axi_rdata,    // read data
    output logic [1:0]       s_axi_rresp,    // read response
    output logic             s_axi_rvalid,   // read data valid
    input  wire logic        s_axi_rready    // read data ready
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0]  aw_addr;
    logic        aw_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        w_held;
    logic        wr_fire;
    logic        wr_ok;
    logic [15:0] nv_pgain;
    logic [15:0] nv_igain;
    logic [15:0] nv_dgain;
    logic [5:0]  nv_step;
    logic [2:0]  nv_baud;
    logic [5:0]  step_mul;
    logic [1:0]  enc_mode;
    logic [2:0]  baud_sel;
    logic        store_gain;
    logic        store_step;
    logic        store_baud;
    logic        load_gain;
    logic        clr_pos;
    logic        step_q;
    logic        enc_a_q;
    logic        enc_b_q;
    logic [15:0] wr_gain;
    logic [31:0] next_rdata;
    logic [1:0]  next_rresp;

    ////////////////////////////////////////////////////////////////////////
    // write channel: address and data taken in either order, then one response
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end
        else if (wr_fire)
            aw_held <= 1'b0;
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
        else if (wr_fire)
            w_held <= 1'b0;
    end

    // ready outputs are combinational from flops; all other outputs are flops
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= SPP_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? SPP_RESP_OKAY : SPP_RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // gains take both low bytes; out-of-range values are refused with slverr
    assign wr_gain = w_data[15:0];

    always_comb
    begin
        unique case (aw_addr)
            SPP_ADDR_CTRL, SPP_ADDR_BAUD, SPP_ADDR_ENCMUL:
                wr_ok = 1'b1;
            SPP_ADDR_PGAIN, SPP_ADDR_IGAIN, SPP_ADDR_DGAIN:
                wr_ok = (w_data[31:16] == 16'h0000) && (wr_gain <= SPP_GAIN_MAX); // RULE_08
            SPP_ADDR_STEPMUL:
                wr_ok = (w_data[31:6] == 26'h0) && (w_data[5:0] >= SPP_STEP_MIN)
                        && (w_data[5:0] <= SPP_STEP_MAX); // RULE_01
            default:
                wr_ok = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // working parameters
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            proportional_gain_o <= SPP_PGAIN_RST; // RULE_08
            integral_gain_o     <= SPP_IGAIN_RST;
            derivative_gain_o   <= SPP_DGAIN_RST;
        end
        else if (load_gain)
        begin
            proportional_gain_o <= nv_pgain; // RULE_03
            integral_gain_o     <= nv_igain;
            derivative_gain_o   <= nv_dgain;
        end
        else if (wr_fire && wr_ok && w_strb[1:0] == 2'h3)
        begin
            if (aw_addr == SPP_ADDR_PGAIN)
                proportional_gain_o <= wr_gain;
            if (aw_addr == SPP_ADDR_IGAIN)
                integral_gain_o <= wr_gain;
            if (aw_addr == SPP_ADDR_DGAIN)
                derivative_gain_o <= wr_gain;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            step_mul <= SPP_STEP_RST;
            enc_mode <= SPP_ENC_X1;
            baud_sel <= SPP_BAUD_RST;
        end
        else if (wr_fire && wr_ok && w_strb[0])
        begin
            if (aw_addr == SPP_ADDR_STEPMUL)
                step_mul <= w_data[5:0]; // RULE_01
            if (aw_addr == SPP_ADDR_ENCMUL && w_data[1:0] != 2'h3)
                enc_mode <= w_data[1:0]; // RULE_02
            if (aw_addr == SPP_ADDR_BAUD)
                baud_sel <= w_data[2:0];
        end
    end

    // command pulses, one cycle each
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            store_gain <= 1'b0;
            store_step <= 1'b0;
            store_baud <= 1'b0;
            load_gain  <= 1'b0;
            clr_pos    <= 1'b0;
        end
        else
        begin
            store_gain <= wr_fire && aw_addr == SPP_ADDR_CTRL && w_strb[0]
                          && w_data[SPP_CTRL_STORE_GAIN]; // RULE_04
            store_step <= wr_fire && aw_addr == SPP_ADDR_CTRL && w_strb[0]
                          && w_data[SPP_CTRL_STORE_STEP]; // RULE_05
            store_baud <= wr_fire && aw_addr == SPP_ADDR_CTRL && w_strb[0]
                          && w_data[SPP_CTRL_STORE_BAUD]; // RULE_06
            load_gain  <= wr_fire && aw_addr == SPP_ADDR_CTRL && w_strb[0]
                          && w_data[SPP_CTRL_LOAD_GAIN];
            clr_pos    <= wr_fire && aw_addr == SPP_ADDR_CTRL && w_strb[0]
                          && w_data[SPP_CTRL_CLR_POS];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // nonvolatile copies
    spp_nv_cell #(.W(16), .RST(SPP_PGAIN_RST)) u_nv_p (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .store_i   (store_gain),
        .data_i    (proportional_gain_o),
        .data_o    (nv_pgain)
    );
    spp_nv_cell #(.W(16), .RST(SPP_IGAIN_RST)) u_nv_i (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .store_i   (store_gain),
        .data_i    (integral_gain_o),
        .data_o    (nv_igain)
    );
    spp_nv_cell #(.W(16), .RST(SPP_DGAIN_RST)) u_nv_d (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .store_i   (store_gain),
        .data_i    (derivative_gain_o),
        .data_o    (nv_dgain)
    );
    spp_nv_cell #(.W(6), .RST(SPP_STEP_RST)) u_nv_step (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .store_i   (store_step),
        .data_i    (step_mul),
        .data_o    (nv_step)
    );
    spp_nv_cell #(.W(3), .RST(SPP_BAUD_RST)) u_nv_baud (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .store_i   (store_baud),
        .data_i    (baud_sel),
        .data_o    (nv_baud)
    );

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            baud_sel_o <= SPP_BAUD_RST;
        else
            baud_sel_o <= nv_baud; // RULE_06
    end

    ////////////////////////////////////////////////////////////////////////
    // step input: rising edge moves position by the multiplier, up when dir_i is high, down when low
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            step_q    <= 1'b0;
            cmd_pos_o <= 32'h0000_0000;
        end
        else
        begin
            step_q <= step_i;
            if (clr_pos)
                cmd_pos_o <= 32'h0000_0000;
            else if (step_i && !step_q)
                cmd_pos_o <= dir_i ? cmd_pos_o + {26'h0, step_mul}
                                   : cmd_pos_o - {26'h0, step_mul}; // RULE_01
        end
    end

    // quadrature: x1 counts a rising, x2 both a edges, x4 every edge
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            enc_a_q  <= 1'b0;
            enc_b_q  <= 1'b0;
            fb_pos_o <= 32'h0000_0000;
        end
        else
        begin
            enc_a_q <= enc_a_i;
            enc_b_q <= enc_b_i;
            if (clr_pos)
                fb_pos_o <= 32'h0000_0000;
            else if (enc_a_i != enc_a_q
                     && (enc_mode != SPP_ENC_X1 || enc_a_i))
                fb_pos_o <= (enc_a_i ^ enc_b_i) ? fb_pos_o - 32'h1
                                                : fb_pos_o + 32'h1; // RULE_02
            else if (enc_b_i != enc_b_q && enc_mode == SPP_ENC_X4)
                fb_pos_o <= (enc_a_i ^ enc_b_i) ? fb_pos_o + 32'h1
                                                : fb_pos_o - 32'h1; // RULE_02
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read channel: one cycle after address acceptance
    assign s_axi_arready = !s_axi_rvalid;

    always_comb
    begin
        next_rresp = SPP_RESP_OKAY;
        unique case (s_axi_araddr)
            SPP_ADDR_CTRL:     next_rdata = 32'h0000_0000;
            SPP_ADDR_STATUS:   next_rdata = {30'h0, enc_mode};
            SPP_ADDR_PGAIN:    next_rdata = {16'h0, proportional_gain_o};
            SPP_ADDR_IGAIN:    next_rdata = {16'h0, integral_gain_o};
            SPP_ADDR_DGAIN:    next_rdata = {16'h0, derivative_gain_o};
            SPP_ADDR_STEPMUL:  next_rdata = {26'h0, step_mul};
            SPP_ADDR_ENCMUL:   next_rdata = {30'h0, enc_mode};
            SPP_ADDR_BAUD:     next_rdata = {29'h0, baud_sel};
            SPP_ADDR_POS:      next_rdata = fb_pos_o;
            SPP_ADDR_VERSION:  next_rdata = {16'h0, SPP_FW_VERSION}; // RULE_07
            SPP_ADDR_NV_PGAIN: next_rdata = {16'h0, nv_pgain}; // RULE_03
            SPP_ADDR_NV_IGAIN: next_rdata = {16'h0, nv_igain}; // RULE_03
            SPP_ADDR_NV_DGAIN: next_rdata = {16'h0, nv_dgain}; // RULE_03
            SPP_ADDR_NV_STEP:  next_rdata = {26'h0, nv_step}; // RULE_07
            SPP_ADDR_NV_BAUD:  next_rdata = {29'h0, nv_baud}; // RULE_07
            default:
            begin
                next_rdata = 32'h0000_0000;
                next_rresp = SPP_RESP_SLVERR;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= SPP_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= next_rresp;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    property p_step_adv;
        @(posedge clk_i) disable iff (!reset_n_i)
        (step_i && !step_q && !clr_pos && dir_i)
            |=> cmd_pos_o == $past(cmd_pos_o) + {26'h0, $past(step_mul)};
    endproperty
    a_step_adv: assert property (p_step_adv) else $error("step advance wrong"); // RULE_01
    property p_step_range;
        @(posedge clk_i) disable iff (!reset_n_i)
        step_mul >= SPP_STEP_MIN && step_mul <= SPP_STEP_MAX;
    endproperty
    a_step_range: assert property (p_step_range) else $error("step mult range"); // RULE_01
    property p_enc_x1;
        @(posedge clk_i) disable iff (!reset_n_i)
        (enc_mode == SPP_ENC_X1 && !clr_pos && enc_b_i == enc_b_q && enc_a_i == enc_a_q)
            |=> fb_pos_o == $past(fb_pos_o);
    endproperty
    a_enc_x1: assert property (p_enc_x1) else $error("encoder moved idle"); // RULE_02
    property p_load;
        @(posedge clk_i) disable iff (!reset_n_i)
        load_gain |=> proportional_gain_o == $past(nv_pgain);
    endproperty
    a_load: assert property (p_load) else $error("gain load wrong"); // RULE_03
    property p_store_gain;
        @(posedge clk_i) disable iff (!reset_n_i)
        store_gain |=> nv_igain == $past(integral_gain_o);
    endproperty
    a_store_gain: assert property (p_store_gain) else $error("gain store wrong"); // RULE_04
    property p_store_step;
        @(posedge clk_i) disable iff (!reset_n_i)
        store_step |=> nv_step == $past(step_mul);
    endproperty
    a_store_step: assert property (p_store_step) else $error("step store wrong"); // RULE_05
    property p_store_baud;
        @(posedge clk_i) disable iff (!reset_n_i)
        store_baud |=> ##1 baud_sel_o == $past(baud_sel, 2);
    endproperty
    a_store_baud: assert property (p_store_baud) else $error("baud store wrong"); // RULE_06
    property p_version;
        @(posedge clk_i) disable iff (!reset_n_i)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == SPP_ADDR_VERSION)
            |=> s_axi_rvalid && s_axi_rdata == {16'h0, SPP_FW_VERSION};
    endproperty
    a_version: assert property (p_version) else $error("version read wrong"); // RULE_07
    property p_gain_max;
        @(posedge clk_i) disable iff (!reset_n_i)
        proportional_gain_o <= SPP_GAIN_MAX && integral_gain_o <= SPP_GAIN_MAX
            && derivative_gain_o <= SPP_GAIN_MAX;
    endproperty
    a_gain_max: assert property (p_gain_max) else $error("gain over limit"); // RULE_08
    c_store: cover property (@(posedge clk_i) disable iff (!reset_n_i) store_gain);
    c_step: cover property (@(posedge clk_i) disable iff (!reset_n_i)
        step_i && !step_q && step_mul == SPP_STEP_MAX);
    c_x4: cover property (@(posedge clk_i) disable iff (!reset_n_i)
        enc_mode == SPP_ENC_X4 && enc_b_i != enc_b_q);
endmodule
`default_nettype wire

/* File: testbench/spp_motion_model.sv */
// far-side model: step command generator and quadrature encoder
`timescale 1ns/1ps
`default_nettype none
module spp_motion_model (
    input  wire logic clk_i,   // system clock
    output logic      step_o,  // step line
    output logic      dir_o,   // direction line
    output logic      enc_a_o, // encoder channel a
    output logic      enc_b_o  // encoder channel b
);
    logic [1:0] phase;
    initial
    begin
        step_o  = 1'b0;
        dir_o   = 1'b0;
        enc_a_o = 1'b0;
        enc_b_o = 1'b0;
        phase   = 2'h0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // direction settles a cycle ahead of the first pulse; gap mimics a slow generator
    task automatic steps(input logic dir, input logic [31:0] n, input logic [31:0] gap);
        dir_o <= dir;
        @(posedge clk_i);
        repeat (n)
        begin
            step_o <= 1'b1;
            @(posedge clk_i);
            step_o <= 1'b0;
            repeat (gap + 1) @(posedge clk_i);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // gray sequence, channel b leads when moving forward
    task automatic turn(input logic fwd, input logic [31:0] n, input logic [31:0] gap);
        repeat (4 * n)
        begin
            phase = fwd ? phase + 2'h1 : phase - 2'h1;
            enc_a_o <= phase[1];
            enc_b_o <= phase[0] ^ phase[1];
            repeat (gap + 1) @(posedge clk_i);
        end
    endtask
endmodule
`default_nettype wire

/* File: testbench/tb_spp_top.sv */
// self-checking bench for the servo position parameter block
`timescale 1ns/1ps
`default_nettype none
module tb_spp_top import spp_pkg::*;;
    logic        clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        step_i, dir_i, enc_a_i, enc_b_i;
    logic [31:0] cmd_pos, fb_pos, wdata, rdata;
    logic [15:0] pg, ig, dg;
    logic [2:0]  baud_sel;
    logic [7:0]  awaddr, araddr;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, d;
    logic [31:0] m, cur, n, k, f, b, gp, exp_cmd, exp_fb;
    int          err_count = 0;
    int          compares = 0;
    int          cycles = 0;
    int          seed = 32'hea3e7333;
    always #5 clk_i = ~clk_i;
    spp_motion_model u_model (.clk_i(clk_i), .step_o(step_i), .dir_o(dir_i),
        .enc_a_o(enc_a_i), .enc_b_o(enc_b_i));
    spp_top u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .step_i(step_i), .dir_i(dir_i),
        .enc_a_i(enc_a_i), .enc_b_i(enc_b_i), .cmd_pos_o(cmd_pos), .fb_pos_o(fb_pos),
        .proportional_gain_o(pg), .integral_gain_o(ig), .derivative_gain_o(dg),
        .baud_sel_o(baud_sel), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            err_count++;
            $display("unexpected %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic check_resp(input string what, input logic [1:0] e, input logic [1:0] g);
        compares++;
        if (g !== e)
        begin
            err_count++;
            $display("unexpected %s expected %h seen %h", what, e, g);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] dv, input logic [1:0] er);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= dv;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do
        begin
            @(posedge clk_i);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
        end
        while (!(bvalid && bready));
        check_resp($sformatf("bresp %h", a), er, bresp);
        bready <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ev);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do
        begin
            @(posedge clk_i);
            if (arvalid && arready)
                arvalid <= 1'b0;
        end
        while (!(rvalid && rready));
        check_resp($sformatf("rresp %h", a), er, rresp);
        check($sformatf("rdata %h", a), ev, rdata);
        rready <= 1'b0;
        @(posedge clk_i);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            err_count++;
            print_verdict();
        end
    end
    initial
    begin
        {awaddr, araddr, wdata} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        wstrb = 4'hF;
        repeat (4) @(posedge clk_i);
        reset_n_i <= 1'b1;
        // host reads the gains, step, encoder mode, version, stored pgain and baud after connecting
        rd(SPP_ADDR_PGAIN, SPP_RESP_OKAY, 32'(SPP_PGAIN_RST));
        rd(SPP_ADDR_IGAIN, SPP_RESP_OKAY, 32'(SPP_IGAIN_RST));
        rd(SPP_ADDR_DGAIN, SPP_RESP_OKAY, 32'(SPP_DGAIN_RST));
        rd(SPP_ADDR_STEPMUL, SPP_RESP_OKAY, 32'(SPP_STEP_RST));
        rd(SPP_ADDR_ENCMUL, SPP_RESP_OKAY, 32'(SPP_ENC_X1));
        rd(SPP_ADDR_VERSION, SPP_RESP_OKAY, 32'(SPP_FW_VERSION));
        rd(SPP_ADDR_NV_PGAIN, SPP_RESP_OKAY, 32'(SPP_PGAIN_RST));
        rd(SPP_ADDR_NV_BAUD, SPP_RESP_OKAY, 32'(SPP_BAUD_RST));
        rd(SPP_ADDR_CTRL, SPP_RESP_OKAY, 32'h0);
        check("pgain", 32'(SPP_PGAIN_RST), 32'(pg));
        // gains at and beyond the top of their range
        gp = 32'($unsigned($random(seed)) % 32769);
        wr(SPP_ADDR_PGAIN, gp, SPP_RESP_OKAY);
        wr(SPP_ADDR_IGAIN, 32'h8000, SPP_RESP_OKAY);
        wr(SPP_ADDR_DGAIN, 32'h8001, SPP_RESP_SLVERR);
        check("pgain", gp, 32'(pg));
        check("igain", 32'h8000, 32'(ig));
        check("dgain", 32'h0, 32'(dg));
        rd(SPP_ADDR_NV_PGAIN, SPP_RESP_OKAY, 32'(SPP_PGAIN_RST));
        wr(SPP_ADDR_CTRL, 32'h1 << SPP_CTRL_STORE_GAIN, SPP_RESP_OKAY);
        rd(SPP_ADDR_NV_PGAIN, SPP_RESP_OKAY, gp);
        rd(SPP_ADDR_NV_IGAIN, SPP_RESP_OKAY, 32'h8000);
        wr(SPP_ADDR_PGAIN, 32'h7, SPP_RESP_OKAY);
        wr(SPP_ADDR_CTRL, 32'h1 << SPP_CTRL_LOAD_GAIN, SPP_RESP_OKAY);
        repeat (2) @(posedge clk_i);
        check("pgain", gp, 32'(pg));
        // step multiplier: out of range both sides, both limits, random
        {cur, exp_cmd, exp_fb} = {32'h1, 64'h0};
        for (int i = 0; i < 6; i++)
        begin
            m = (i == 0) ? 32'h0 : (i == 1) ? 32'h33 : (i == 2) ? 32'h1 : (i == 3) ? 32'h32
                : 32'h1 + 32'($unsigned($random(seed)) % 50);
            wr(SPP_ADDR_STEPMUL, m, (m >= 1 && m <= 50) ? SPP_RESP_OKAY : SPP_RESP_SLVERR);
            cur = (m >= 1 && m <= 50) ? m : cur;
            n = 32'h1 + 32'($unsigned($random(seed)) % 8);
            d = 1'($random(seed));
            u_model.steps(d, n, 32'($unsigned($random(seed)) % 3));
            repeat (2) @(posedge clk_i);
            exp_cmd = d ? exp_cmd + cur * n : exp_cmd - cur * n;
            check("cmd_pos", exp_cmd, cmd_pos);
        end
        wr(SPP_ADDR_CTRL, 32'h1 << SPP_CTRL_STORE_STEP, SPP_RESP_OKAY);
        rd(SPP_ADDR_NV_STEP, SPP_RESP_OKAY, cur);
        // encoder modes; code 3 is ignored and x4 stays
        for (k = 0; k < 4; k++)
        begin
            wr(SPP_ADDR_ENCMUL, k, SPP_RESP_OKAY);
            f = (k == 0) ? 32'h1 : (k == 1) ? 32'h2 : 32'h4;
            n = 32'h1 + 32'($unsigned($random(seed)) % 5);
            d = 1'($random(seed));
            u_model.turn(d, n, 32'($unsigned($random(seed)) % 2));
            repeat (2) @(posedge clk_i);
            exp_fb = d ? exp_fb + f * n : exp_fb - f * n;
            check("fb_pos", exp_fb, fb_pos);
            rd(SPP_ADDR_POS, SPP_RESP_OKAY, exp_fb);
        end
        // baud kept in storage only after the save command
        b = 32'h1 + 32'($unsigned($random(seed)) % 7);
        wr(SPP_ADDR_BAUD, b, SPP_RESP_OKAY);
        check("baud_sel", 32'(SPP_BAUD_RST), 32'(baud_sel));
        wr(SPP_ADDR_CTRL, 32'h1 << SPP_CTRL_STORE_BAUD, SPP_RESP_OKAY);
        repeat (2) @(posedge clk_i);
        check("baud_sel", b, 32'(baud_sel));
        rd(SPP_ADDR_NV_BAUD, SPP_RESP_OKAY, b);
        rd(8'h3C, SPP_RESP_SLVERR, 32'h0);
        wr(8'h3C, 32'h5, SPP_RESP_SLVERR);
        wr(SPP_ADDR_CTRL, 32'h1 << SPP_CTRL_CLR_POS, SPP_RESP_OKAY);
        repeat (2) @(posedge clk_i);
        check("cmd_pos", 32'h0, cmd_pos);
        check("fb_pos", 32'h0, fb_pos);
        print_verdict();
    end
endmodule
`default_nettype wire
